// ---- core/fsc_pkg.sv ----
package fsc_pkg;

  // Clock and busy-cycle timing
  localparam int CLOCK_PERIOD_NS   = 8;
  localparam int REG_WRITE_TIME_NS = 40;
  localparam int REG_WRITE_CYCLES  = (REG_WRITE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int ARRAY_OP_TIME_NS  = 2000;
  localparam int ARRAY_OP_CYCLES   = (ARRAY_OP_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int BUSY_CNT_W        = 12;

  // Status register layout
  localparam int ST_LOCK_BIT  = 7;
  localparam int ST_QUAD_BIT  = 6;
  localparam int ST_PROT_HI   = 5;
  localparam int ST_PROT_LO   = 2;
  localparam int ST_LATCH_BIT = 1;
  localparam int ST_BUSY_BIT  = 0;

  // Configuration register layout
  localparam int CF_DC_HI        = 7;
  localparam int CF_DC_LO        = 6;
  localparam int CF_WIDE_BIT     = 5;
  localparam int CF_PREAMBLE_BIT = 4;
  localparam int CF_LOW_END_BIT  = 3;
  localparam int CF_DRIVE_HI     = 2;
  localparam int CF_DRIVE_LO     = 0;

  // Reset values; drive strength comes up at its strongest code
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] CONFIG_RESET = 8'h07;

  // Dummy clocks per dummy-count code
  localparam logic [3:0] DUMMY_CODE0 = 4'h8;
  localparam logic [3:0] DUMMY_CODE1 = 4'h6;
  localparam logic [3:0] DUMMY_CODE2 = 4'h8;
  localparam logic [3:0] DUMMY_CODE3 = 4'ha;

  typedef enum logic [2:0] {
    FSC_OP_NOP,
    FSC_OP_WRITE_ENABLE,
    FSC_OP_WRITE_DISABLE,
    FSC_OP_WRITE_REGS,
    FSC_OP_ENTER_WIDE,
    FSC_OP_EXIT_WIDE,
    FSC_OP_ARRAY
  } fsc_op_t;

  function automatic logic [3:0] dummy_clocks(input logic [1:0] code);
    case (code)
      2'h0:    dummy_clocks = DUMMY_CODE0;
      2'h1:    dummy_clocks = DUMMY_CODE1;
      2'h2:    dummy_clocks = DUMMY_CODE2;
      default: dummy_clocks = DUMMY_CODE3;
    endcase
  endfunction

endpackage

// ---- core/fsc_busy_timer.sv ----
`timescale 1ns/10ps
module fsc_busy_timer #(
  parameter int CNT_W = 12
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             start,
  input  wire logic [CNT_W-1:0] load,
  output logic                  done
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             done;
  } fsc_timer_t;

  fsc_timer_t q;
  fsc_timer_t d;

  initial begin
    if (CNT_W < 2) $error("CNT_W too small");
  end

  always_comb begin
    d      = q;
    d.done = 1'b0;
    if (start) begin
      d.cnt = load;
    end else if (q.cnt != '0) begin
      d.cnt = q.cnt - 1'b1;
      // Pulse as the last cycle elapses
      d.done = (q.cnt == CNT_W'(1));
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign done = q.done;

endmodule

// ---- core/fsc_regs.sv ----
`timescale 1ns/10ps
// Operation
// R1: Status byte: lock, quad, protect level, latch, busy
// R2: Lock set blocks status register writes
// R3: Drive select, bits 2-0, only via write-regs
// R4: Low-end protect bit 3 resets to top
// R5: Low-end protect is one-time settable only
// R6: Preamble enable bit 4, volatile, default off
// R7: Host changes preamble only via write-regs
// R8: Enter-wide command sets wide address flag
// R9: Wide flag resets zero; exit command clears
// R10: Config bit 5 reports the wide flag
// R11: Config bits 7-6 select dummy count
// R12: Written config field replaces default behaviour
// R13: Dummy codes give 8, 6, 8, 10 clocks
// R14: Quad disabled ignores quad commands, pins normal
// R15: Busy reads one during program, erase, write
// R16: Write-enable sets latch; needed; cleared at completion
// R17: Drive select resets all ones, strongest
// R18: Busy and latch unaffected by written data
module fsc_regs #(
  parameter int REG_WRITE_CYCLES = fsc_pkg::REG_WRITE_CYCLES,
  parameter int ARRAY_OP_CYCLES  = fsc_pkg::ARRAY_OP_CYCLES
) (
  input  wire logic            CLOCK,
  input  wire logic            RST_N,
  input  wire logic            CMD_VALID,
  input  wire fsc_pkg::fsc_op_t CMD_OP,
  input  wire logic            CMD_QUAD,
  input  wire logic [7:0]      CMD_STATUS,
  input  wire logic            CMD_CONFIG_VALID,
  input  wire logic [7:0]      CMD_CONFIG,
  output logic                 CMD_ACCEPT,
  output logic                 CMD_IGNORED,
  output logic                 ARRAY_START,
  output logic [7:0]           STATUS,
  output logic [7:0]           CONFIG,
  output logic [3:0]           DUMMY_CLOCKS
);

  localparam int CW = fsc_pkg::BUSY_CNT_W;
  localparam int BUSY_WAIT_MAX = 300;

  typedef enum logic [1:0] {
    FSC_IDLE,
    FSC_BUSY_REGS,
    FSC_BUSY_ARRAY
  } fsc_state_t;

  typedef struct packed {
    fsc_state_t st;
    logic [7:0] status;
    logic [7:0] config_r;
    logic [3:0] dummy;
    logic       accept;
    logic       ignored;
    logic       array_start;
  } fsc_regs_t;

  fsc_regs_t      q;
  fsc_regs_t      d;
  logic           timer_start;
  logic [CW-1:0]  timer_load;
  logic           timer_done;

  initial begin
    if (REG_WRITE_CYCLES < 1 || REG_WRITE_CYCLES >= (1 << CW))
      $error("REG_WRITE_CYCLES out of range");
    if (ARRAY_OP_CYCLES < 1 || ARRAY_OP_CYCLES >= (1 << CW))
      $error("ARRAY_OP_CYCLES out of range");
    if (REG_WRITE_CYCLES > BUSY_WAIT_MAX - 2)
      $error("REG_WRITE_CYCLES too long for checks");
  end

  fsc_busy_timer #(
    .CNT_W (CW)
  ) u_timer (
    .clk   (CLOCK),
    .rst_n (RST_N),
    .start (timer_start),
    .load  (timer_load),
    .done  (timer_done)
  );

  always_comb begin
    d             = q;
    d.accept      = 1'b0;
    d.ignored     = 1'b0;
    d.array_start = 1'b0;
    timer_start   = 1'b0;
    timer_load    = '0;
    // Completion ends busy and drops the latch
    if (timer_done) begin
      d.st = FSC_IDLE;
      d.status[fsc_pkg::ST_BUSY_BIT]  = 1'b0; // R15
      d.status[fsc_pkg::ST_LATCH_BIT] = 1'b0; // R16
    end
    if (CMD_VALID && CMD_OP != fsc_pkg::FSC_OP_NOP) begin
      // Nothing is taken while a cycle runs
      if (q.status[fsc_pkg::ST_BUSY_BIT]) begin
        d.ignored = 1'b1;
      end else if (CMD_QUAD && !q.status[fsc_pkg::ST_QUAD_BIT]) begin
        d.ignored = 1'b1; // R14
      end else begin
        d.accept = 1'b1;
        case (CMD_OP)
          fsc_pkg::FSC_OP_WRITE_ENABLE: begin
            d.status[fsc_pkg::ST_LATCH_BIT] = 1'b1; // R16
          end
          fsc_pkg::FSC_OP_WRITE_DISABLE: begin
            d.status[fsc_pkg::ST_LATCH_BIT] = 1'b0;
          end
          fsc_pkg::FSC_OP_ENTER_WIDE: begin
            d.config_r[fsc_pkg::CF_WIDE_BIT] = 1'b1; // R8 R10
          end
          fsc_pkg::FSC_OP_EXIT_WIDE: begin
            d.config_r[fsc_pkg::CF_WIDE_BIT] = 1'b0; // R9
          end
          fsc_pkg::FSC_OP_WRITE_REGS: begin
            if (!q.status[fsc_pkg::ST_LATCH_BIT]) begin
              d.accept  = 1'b0;
              d.ignored = 1'b1;
            end else begin
              // Latch and busy bits never come from the data byte
              if (!q.status[fsc_pkg::ST_LOCK_BIT]) begin // R2
                d.status[fsc_pkg::ST_LOCK_BIT:fsc_pkg::ST_PROT_LO] =
                  CMD_STATUS[fsc_pkg::ST_LOCK_BIT:fsc_pkg::ST_PROT_LO]; // R1 R18
              end
              if (CMD_CONFIG_VALID) begin // R7 R12
                d.config_r[fsc_pkg::CF_DC_HI:fsc_pkg::CF_DC_LO] =
                  CMD_CONFIG[fsc_pkg::CF_DC_HI:fsc_pkg::CF_DC_LO]; // R11
                d.config_r[fsc_pkg::CF_PREAMBLE_BIT] =
                  CMD_CONFIG[fsc_pkg::CF_PREAMBLE_BIT]; // R6
                d.config_r[fsc_pkg::CF_DRIVE_HI:fsc_pkg::CF_DRIVE_LO] =
                  CMD_CONFIG[fsc_pkg::CF_DRIVE_HI:fsc_pkg::CF_DRIVE_LO]; // R3
                // One-time bit: can be set, never cleared
                d.config_r[fsc_pkg::CF_LOW_END_BIT] =
                  q.config_r[fsc_pkg::CF_LOW_END_BIT] |
                  CMD_CONFIG[fsc_pkg::CF_LOW_END_BIT]; // R5
              end
              d.status[fsc_pkg::ST_BUSY_BIT] = 1'b1; // R15
              d.st        = FSC_BUSY_REGS;
              timer_start = 1'b1;
              timer_load  = CW'(REG_WRITE_CYCLES);
            end
          end
          fsc_pkg::FSC_OP_ARRAY: begin
            if (!q.status[fsc_pkg::ST_LATCH_BIT]) begin // R16
              d.accept  = 1'b0;
              d.ignored = 1'b1;
            end else begin
              d.status[fsc_pkg::ST_BUSY_BIT] = 1'b1; // R15
              d.st          = FSC_BUSY_ARRAY;
              d.array_start = 1'b1;
              timer_start   = 1'b1;
              timer_load    = CW'(ARRAY_OP_CYCLES);
            end
          end
          default: begin
            d.accept  = 1'b0;
            d.ignored = 1'b1;
          end
        endcase
      end
    end
    // Registered so the read path sees the setting in force
    d.dummy = fsc_pkg::dummy_clocks(d.config_r[fsc_pkg::CF_DC_HI:fsc_pkg::CF_DC_LO]); // R13
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      q.st          <= FSC_IDLE;
      q.status      <= fsc_pkg::STATUS_RESET;
      q.config_r    <= fsc_pkg::CONFIG_RESET; // R4 R17 R9
      q.dummy       <= fsc_pkg::DUMMY_CODE0;
      q.accept      <= 1'b0;
      q.ignored     <= 1'b0;
      q.array_start <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign CMD_ACCEPT   = q.accept;
  assign CMD_IGNORED  = q.ignored;
  assign ARRAY_START  = q.array_start;
  assign STATUS       = q.status;
  assign CONFIG       = q.config_r;
  assign DUMMY_CLOCKS = q.dummy;

  sequence s_regs_taken;
    CMD_VALID && CMD_OP == fsc_pkg::FSC_OP_WRITE_REGS && !CMD_QUAD &&
      !STATUS[fsc_pkg::ST_BUSY_BIT] && STATUS[fsc_pkg::ST_LATCH_BIT];
  endsequence

  sequence s_busy_then_free;
    STATUS[fsc_pkg::ST_BUSY_BIT] ##[1:BUSY_WAIT_MAX] !STATUS[fsc_pkg::ST_BUSY_BIT];
  endsequence

  property p_lock_blocks;
    @(posedge CLOCK) disable iff (!RST_N)
      s_regs_taken and STATUS[fsc_pkg::ST_LOCK_BIT] |=> $stable(STATUS[7:2]);
  endproperty
  a_lock_blocks: assert property (p_lock_blocks) else $error("locked status changed"); // R2

  property p_drive_only_by_write;
    @(posedge CLOCK) disable iff (!RST_N)
      $changed(CONFIG[2:0]) |-> CMD_ACCEPT && $past(CMD_OP) == fsc_pkg::FSC_OP_WRITE_REGS;
  endproperty
  a_drive_only_by_write: assert property (p_drive_only_by_write)
    else $error("drive select changed without write"); // R3

  property p_low_end_sticky;
    @(posedge CLOCK) disable iff (!RST_N)
      CONFIG[fsc_pkg::CF_LOW_END_BIT] |=> CONFIG[fsc_pkg::CF_LOW_END_BIT];
  endproperty
  a_low_end_sticky: assert property (p_low_end_sticky) else $error("low-end bit cleared"); // R5

  property p_enter_wide;
    @(posedge CLOCK) disable iff (!RST_N)
      CMD_VALID && CMD_OP == fsc_pkg::FSC_OP_ENTER_WIDE && !CMD_QUAD &&
      !STATUS[fsc_pkg::ST_BUSY_BIT] |=> CONFIG[fsc_pkg::CF_WIDE_BIT] && CMD_ACCEPT;
  endproperty
  a_enter_wide: assert property (p_enter_wide) else $error("wide flag not set"); // R8

  property p_exit_wide;
    @(posedge CLOCK) disable iff (!RST_N)
      CMD_VALID && CMD_OP == fsc_pkg::FSC_OP_EXIT_WIDE && !CMD_QUAD &&
      !STATUS[fsc_pkg::ST_BUSY_BIT] |=> !CONFIG[fsc_pkg::CF_WIDE_BIT];
  endproperty
  a_exit_wide: assert property (p_exit_wide) else $error("wide flag not cleared"); // R9

  property p_dummy_map;
    @(posedge CLOCK) disable iff (!RST_N)
      DUMMY_CLOCKS == fsc_pkg::dummy_clocks(CONFIG[7:6]);
  endproperty
  a_dummy_map: assert property (p_dummy_map) else $error("dummy count mismatch"); // R13

  property p_quad_ignored;
    @(posedge CLOCK) disable iff (!RST_N)
      CMD_VALID && CMD_OP != fsc_pkg::FSC_OP_NOP && CMD_QUAD &&
      !STATUS[fsc_pkg::ST_QUAD_BIT] |=> CMD_IGNORED && !CMD_ACCEPT && $stable(CONFIG);
  endproperty
  a_quad_ignored: assert property (p_quad_ignored) else $error("quad command taken"); // R14

  property p_busy_span;
    @(posedge CLOCK) disable iff (!RST_N)
      s_regs_taken |=> s_busy_then_free;
  endproperty
  a_busy_span: assert property (p_busy_span) else $error("busy span wrong"); // R15

  property p_latch_needed;
    @(posedge CLOCK) disable iff (!RST_N)
      CMD_VALID && CMD_OP == fsc_pkg::FSC_OP_ARRAY && !STATUS[fsc_pkg::ST_LATCH_BIT]
      |=> CMD_IGNORED && !ARRAY_START && !STATUS[fsc_pkg::ST_BUSY_BIT];
  endproperty
  a_latch_needed: assert property (p_latch_needed) else $error("array op without latch"); // R16

  property p_latch_clears;
    @(posedge CLOCK) disable iff (!RST_N)
      $fell(STATUS[fsc_pkg::ST_BUSY_BIT]) |-> !STATUS[fsc_pkg::ST_LATCH_BIT];
  endproperty
  a_latch_clears: assert property (p_latch_clears) else $error("latch kept after cycle"); // R16

  property p_ro_bits;
    @(posedge CLOCK) disable iff (!RST_N)
      s_regs_taken |=> STATUS[1:0] == 2'h3;
  endproperty
  a_ro_bits: assert property (p_ro_bits) else $error("read-only bits written"); // R18

endmodule

// ---- test/fsc_host_model.sv ----
`timescale 1ns/10ps
module fsc_host_model (
  input  wire logic       clock,
  output fsc_pkg::fsc_op_t cmd_op,
  output logic            cmd_valid,
  output logic            cmd_quad,
  output logic [7:0]      cmd_status,
  output logic            cmd_config_valid,
  output logic [7:0]      cmd_config
);
  initial begin
    cmd_valid = 1'b0;
    cmd_op = fsc_pkg::FSC_OP_NOP;
    cmd_quad = 1'b0;
    cmd_status = 8'h00;
    cmd_config_valid = 1'b0;
    cmd_config = 8'h00;
  end

  // Register bytes only travel inside a write-regs command
  task automatic send(input fsc_pkg::fsc_op_t op, input logic q, input logic [7:0] s,
                      input logic cv, input logic [7:0] c);
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_quad = q;
    cmd_status = s;
    cmd_config_valid = cv;
    cmd_config = c;
    @(negedge clock);
    cmd_valid = 1'b0;
    cmd_op = fsc_pkg::FSC_OP_NOP;
    cmd_config_valid = 1'b0;
    // Released data lines do not keep the last value
    cmd_status = ~s;
    cmd_config = ~c;
    // Returns mid-cycle so the one-cycle answer pulse is still standing
  endtask
endmodule

// ---- test/testbench.sv ----
`timescale 1ns/10ps
module testbench;
  localparam int RW = 2;
  localparam int AO = 3;
  logic             clock;
  logic             rst_n;
  fsc_pkg::fsc_op_t cmd_op;
  logic             cmd_valid;
  logic             cmd_quad;
  logic [7:0]       cmd_status;
  logic             cmd_config_valid;
  logic [7:0]       cmd_config;
  logic             accept;
  logic             ignored;
  logic             array_start;
  logic [7:0]       status;
  logic [7:0]       config_q;
  logic [3:0]       dummy;
  int               miscompares;
  int               comparisons;

  fsc_host_model i_fsc_host_model (
    .clock(clock), .cmd_op(cmd_op), .cmd_valid(cmd_valid), .cmd_quad(cmd_quad),
    .cmd_status(cmd_status), .cmd_config_valid(cmd_config_valid), .cmd_config(cmd_config));

  fsc_regs #(.REG_WRITE_CYCLES(RW), .ARRAY_OP_CYCLES(AO)) i_fsc_regs (
    .CLOCK(clock), .RST_N(rst_n), .CMD_VALID(cmd_valid), .CMD_OP(cmd_op),
    .CMD_QUAD(cmd_quad), .CMD_STATUS(cmd_status), .CMD_CONFIG_VALID(cmd_config_valid),
    .CMD_CONFIG(cmd_config), .CMD_ACCEPT(accept), .CMD_IGNORED(ignored),
    .ARRAY_START(array_start), .STATUS(status), .CONFIG(config_q), .DUMMY_CLOCKS(dummy));

  always #4 clock = ~clock;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmd(input fsc_pkg::fsc_op_t op, input logic q);
    i_fsc_host_model.send(op, q, 8'h00, 1'b0, 8'h00);
  endtask

  // Write the status register, and the config register when cv is set, and walk the busy period to its end
  task automatic wr(input logic [7:0] s, input logic cv, input logic [7:0] c);
    cmd(fsc_pkg::FSC_OP_WRITE_ENABLE, 1'b0);
    chk({7'h0, accept}, 8'h01);
    i_fsc_host_model.send(fsc_pkg::FSC_OP_WRITE_REGS, 1'b0, s, cv, c);
    chk({7'h0, accept}, 8'h01);
    // Busy stands one cycle beyond the loaded count: timer pulse is registered
    repeat (RW) @(posedge clock);
    #1;
    chk({6'h0, status[1:0]}, 8'h03);
    @(posedge clock);
    #1;
    chk({6'h0, status[1:0]}, 8'h00);
  endtask

  task automatic t_reset;
    chk(status, 8'h00);
    chk(config_q, 8'h07);
    chk({4'h0, dummy}, 8'h08);
  endtask

  task automatic t_latch;
    i_fsc_host_model.send(fsc_pkg::FSC_OP_WRITE_REGS, 1'b0, 8'h3c, 1'b1, 8'h10);
    chk({7'h0, ignored}, 8'h01);
    chk(config_q, 8'h07);
    cmd(fsc_pkg::FSC_OP_WRITE_ENABLE, 1'b0);
    chk(status, 8'h02);
    cmd(fsc_pkg::FSC_OP_WRITE_DISABLE, 1'b0);
    chk(status, 8'h00);
  endtask

  task automatic t_array;
    cmd(fsc_pkg::FSC_OP_ARRAY, 1'b0);
    chk({6'h0, ignored, array_start}, 8'h02);
    cmd(fsc_pkg::FSC_OP_WRITE_ENABLE, 1'b0);
    cmd(fsc_pkg::FSC_OP_ARRAY, 1'b0);
    chk({6'h0, accept, array_start}, 8'h03);
    chk(status, 8'h03);
    cmd(fsc_pkg::FSC_OP_WRITE_ENABLE, 1'b0);
    chk({7'h0, ignored}, 8'h01);
    repeat (AO - 2) @(posedge clock);
    #1;
    chk(status, 8'h03);
    @(posedge clock);
    #1;
    chk(status, 8'h00);
  endtask

  task automatic t_regs;
    wr(8'h7f, 1'b1, 8'hf5);
    chk(status, 8'h7c);
    chk(config_q, 8'hd5);
    chk({4'h0, dummy}, 8'h0a);
  endtask

  task automatic t_dummy;
    logic [3:0] exp_dc [4];
    exp_dc = '{4'h8, 4'h6, 4'h8, 4'ha};
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, 1'b1, {i[1:0], 6'h07});
      chk({4'h0, dummy}, {4'h0, exp_dc[i]});
      chk(config_q, {i[1:0], 6'h07});
    end
  endtask

  task automatic t_wide;
    cmd(fsc_pkg::FSC_OP_ENTER_WIDE, 1'b0);
    chk({accept, 6'h0, config_q[5]}, 8'h81);
    cmd(fsc_pkg::FSC_OP_EXIT_WIDE, 1'b0);
    chk({accept, 6'h0, config_q[5]}, 8'h80);
  endtask

  task automatic t_quad;
    cmd(fsc_pkg::FSC_OP_WRITE_ENABLE, 1'b1);
    chk({ignored, status[6:0]}, 8'h80);
    wr(8'h40, 1'b0, 8'h00);
    cmd(fsc_pkg::FSC_OP_WRITE_ENABLE, 1'b1);
    chk({accept, status[6:0]}, 8'hc2);
    cmd(fsc_pkg::FSC_OP_WRITE_DISABLE, 1'b0);
  endtask

  task automatic t_lowend_lock;
    wr(8'h40, 1'b1, 8'h08);
    chk(config_q, 8'h08);
    wr(8'h40, 1'b1, 8'h07);
    chk(config_q, 8'h0f);
    wr(8'hc0, 1'b0, 8'h00);
    chk(status, 8'hc0);
    wr(8'h00, 1'b1, 8'h47);
    chk(status, 8'hc0);
    chk(config_q, 8'h4f);
  endtask

  task automatic report_and_stop;
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #50000;
    miscompares++;
    report_and_stop();
  end

  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    miscompares = 0;
    comparisons = 0;
    repeat (12) @(negedge clock);
    rst_n = 1'b1;
    t_reset();
    t_latch();
    t_array();
    t_regs();
    t_dummy();
    t_wide();
    t_quad();
    t_lowend_lock();
    report_and_stop();
  end
endmodule
